// ===== verilog/fhr_front_end.sv
module fhr_front_end
  import fhr_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  input  wire logic [15:0]  hostAddr,
  input  wire logic [7:0]   hostDataIn,
  output logic      [7:0]   hostDataOut,
  output logic              hostDataOe_b,
  input  wire logic         hostRead,
  input  wire logic         hostWrite,
  input  wire logic         dmaAck,
  input  wire logic         configState,
  input  wire logic [1:0]   cfgIndex,
  input  wire logic         cfgWrite,
  input  wire logic [7:0]   cfgData,
  input  wire fhr_disk_in_t diskIn,
  input  wire fhr_core_t    coreIn,
  output logic              softResetActive,
  output logic              enhancedMode2,
  output logic              dmaEnable,
  output logic              dmaPinsDriven,
  output logic              terminalCountHigh,
  output logic              densitySelectHigh,
  output logic [7:0]        outputControl,
  output logic [7:0]        tapeAssign,
  output logic [7:0]        rateSelect,
  output logic [7:0]        rateConfig,
  output logic [7:0]        queueWriteData,
  output logic              queueWrite,
  output logic              queueRead
);
  logic [7:0]   baseHigh_reg;
  logic         blockEnable_reg;
  logic [7:0]   modeCfg_reg;
  logic [7:0]   forceWp_reg;
  logic [7:0]   outputControl_reg;
  logic [7:0]   tape_reg;
  logic [7:0]   rate_reg;
  logic [7:0]   rateCfg_reg;
  logic         stepLatch_reg;
  logic         stepPrev_reg;
  logic [7:0]   readData_reg;
  logic         readDrive_reg;
  logic [7:0]   queueWriteData_reg;
  logic         queueWrite_reg;
  fhr_disk_in_t diskSync;
  fhr_mode_t    mode;
  logic         hit;
  logic         rdHit;
  logic         wrHit;
  logic [2:0]   offs;
  logic         inputRead;
  logic         stepRise;
  logic         forceWp;
  logic         wpActive;
  logic [7:0]   statusA;
  logic [7:0]   readMux;
  logic         readFloats;

  function automatic fhr_mode_t decodeMode(input logic ident,
                                           input logic density);
    // unlisted combination ident high, density low falls to full-host
    if (ident)
      return FHR_FULL_HOST;
    else if (density)
      return FHR_ALT_STATUS;
    else
      return FHR_COMPACT;
  endfunction : decodeMode

  fhr_sync #(
    .WIDTH(3)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .asyncIn (diskIn),
    .syncOut (diskSync)
  );

  assign mode = decodeMode(modeCfg_reg[MODE_BIT_IDENT],
                           modeCfg_reg[MODE_BIT_DENSITY]);
  assign enhancedMode2 = modeCfg_reg[MODE_BIT_ENH2];

  assign hit   = blockEnable_reg && (hostAddr[15:3] ==
                 {5'h00, baseHigh_reg});
  assign offs  = hostAddr[2:0];
  assign rdHit = (hit && hostRead) || (dmaAck && hostRead);
  assign wrHit = (hit && hostWrite) || (dmaAck && hostWrite);
  assign queueRead = rdHit && (dmaAck || offs == OFS_DATA_QUEUE);
  assign inputRead = hit && hostRead && !dmaAck &&
                     offs == OFS_INPUT_CFG;

  assign softResetActive = !outputControl_reg[OCR_BIT_SOFTRST];
  // dma enable honoured except alternate mode
  assign dmaEnable = (mode == FHR_ALT_STATUS) ? 1'b1 :
                     outputControl_reg[OCR_BIT_DMAEN];
  // alternate mode always drives request pins
  assign dmaPinsDriven = dmaEnable;
  assign terminalCountHigh = (mode != FHR_ALT_STATUS);
  assign densitySelectHigh = (mode == FHR_FULL_HOST);

  assign stepRise = coreIn.stepOut && !stepPrev_reg;
  assign forceWp  = forceWp_reg[FWP_BIT_FORCE];
  assign wpActive = !diskSync.writeProtectN || forceWp;

  always_comb begin
    statusA = 8'h00;
    statusA[7] = coreIn.floppyInterruptOut;
    if (mode == FHR_COMPACT) begin
      statusA[0] = !coreIn.stepDirIn;
      statusA[1] = wpActive;
      statusA[2] = !diskSync.indexPulseN;
      statusA[3] = !coreIn.headSide;
      statusA[4] = !diskSync.trackZeroN;
      statusA[5] = stepLatch_reg;
      statusA[6] = coreIn.dmaRequest;
    end else begin
      statusA[0] = coreIn.stepDirIn;
      statusA[1] = !wpActive;
      statusA[2] = diskSync.indexPulseN;
      statusA[3] = coreIn.headSide;
      statusA[4] = diskSync.trackZeroN;
      statusA[5] = coreIn.stepOut;
      statusA[6] = 1'b1;
    end
  end

  always_comb begin
    readMux = 8'h00;
    readFloats = 1'b0;
    if (dmaAck) begin
      readMux = coreIn.queueData;
    end else begin
      case (offs)
        OFS_STATUS_A: begin
          readMux = statusA;
          readFloats = (mode == FHR_FULL_HOST);
        end
        OFS_STATUS_B:   readFloats = 1'b1;
        OFS_OUT_CTRL:   readMux = outputControl_reg;
        OFS_TAPE:       readMux = tape_reg;
        OFS_MAIN_RATE:  readMux = coreIn.mainStatus;
        OFS_DATA_QUEUE: readMux = coreIn.queueData;
        OFS_INPUT_CFG:  readMux = {coreIn.diskChange, 7'h7F};
        default:        readFloats = 1'b1;
      endcase
    end
  end

  // configuration writes gated by config state
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      baseHigh_reg    <= CFG_RESET;
      blockEnable_reg <= 1'b0;
      modeCfg_reg     <= MODE_RESET;
      forceWp_reg     <= CFG_RESET;
    end else if (configState && cfgWrite) begin
      case (cfgIndex)
        2'h0: begin
          baseHigh_reg    <= cfgData;
          blockEnable_reg <= 1'b1;
        end
        2'h1:    modeCfg_reg <= cfgData;
        2'h2:    forceWp_reg <= cfgData;
        default: blockEnable_reg <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      outputControl_reg <= OCR_RESET;
      tape_reg          <= TAPE_RESET;
      rate_reg          <= RATE_RESET;
      rateCfg_reg       <= RATE_RESET;
    end else if (wrHit && !dmaAck) begin
      case (offs)
        // soft reset bit stored with the rest
        OFS_OUT_CTRL:  outputControl_reg <= hostDataIn;
        OFS_TAPE:      tape_reg <= hostDataIn;
        OFS_MAIN_RATE: rate_reg <= hostDataIn;
        OFS_INPUT_CFG: rateCfg_reg <= hostDataIn;
        default:       tape_reg <= tape_reg;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      stepLatch_reg <= 1'b0;
      stepPrev_reg  <= 1'b0;
    end else begin
      stepPrev_reg <= coreIn.stepOut;
      if (stepRise)
        stepLatch_reg <= 1'b1;
      else if (inputRead || softResetActive)
        stepLatch_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      readData_reg       <= 8'h00;
      readDrive_reg      <= 1'b0;
      queueWriteData_reg <= 8'h00;
      queueWrite_reg     <= 1'b0;
    end else begin
      readData_reg   <= readMux;
      readDrive_reg  <= rdHit && !readFloats;
      queueWrite_reg <= wrHit && (dmaAck || offs == OFS_DATA_QUEUE);
      if (wrHit)
        queueWriteData_reg <= hostDataIn;
    end
  end

  assign hostDataOut    = readData_reg;
  assign hostDataOe_b   = !readDrive_reg;
  assign outputControl  = outputControl_reg;
  assign tapeAssign     = tape_reg;
  assign rateSelect     = rate_reg;
  assign rateConfig     = rateCfg_reg;
  assign queueWriteData = queueWriteData_reg;
  assign queueWrite     = queueWrite_reg;

  AST_NO_DECODE_DISABLED: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    !blockEnable_reg && !dmaAck |=> hostDataOe_b)
    else $error("read answered while block disabled");

  AST_CFG_LOCK: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    !configState |=> $stable(modeCfg_reg))
    else $error("mode changed outside configuration state");

  AST_STATUS_A_FLOAT: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    hit && hostRead && !dmaAck && offs == OFS_STATUS_A &&
    mode == FHR_FULL_HOST |=> hostDataOe_b)
    else $error("status A driven in full-host mode");

  AST_BIT6_ONE: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    hit && hostRead && !dmaAck && offs == OFS_STATUS_A &&
    mode == FHR_ALT_STATUS |=> hostDataOut[6] && !hostDataOe_b)
    else $error("status A bit 6 not one");

  AST_ALT_DRIVEN: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    mode == FHR_ALT_STATUS |-> dmaPinsDriven && !terminalCountHigh &&
    !densitySelectHigh)
    else $error("alternate mode pin policy wrong");

  AST_COMPACT_POL: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    mode == FHR_COMPACT |-> terminalCountHigh && !densitySelectHigh &&
    dmaEnable == outputControl_reg[OCR_BIT_DMAEN])
    else $error("compact mode pin policy wrong");

  sequence stepSeen;
    stepRise ##1 (!inputRead && !softResetActive);
  endsequence
  AST_STEP_LATCH: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    stepSeen |-> stepLatch_reg)
    else $error("step latch lost");

  AST_SOFT_RESET: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    hit && hostWrite && !dmaAck && offs == OFS_OUT_CTRL &&
    !hostDataIn[OCR_BIT_SOFTRST] |=> softResetActive)
    else $error("soft reset not entered");

  AST_SOFT_RELEASE: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    hit && hostWrite && !dmaAck && offs == OFS_OUT_CTRL &&
    hostDataIn[OCR_BIT_SOFTRST] |=> !softResetActive)
    else $error("soft reset not left");
endmodule : fhr_front_end

// ===== verilog/fhr_pkg.sv
package fhr_pkg;
  localparam logic [2:0] OFS_STATUS_A   = 3'h0;
  localparam logic [2:0] OFS_STATUS_B   = 3'h1;
  localparam logic [2:0] OFS_OUT_CTRL   = 3'h2;
  localparam logic [2:0] OFS_TAPE       = 3'h3;
  localparam logic [2:0] OFS_MAIN_RATE  = 3'h4;
  localparam logic [2:0] OFS_DATA_QUEUE = 3'h5;
  localparam logic [2:0] OFS_INPUT_CFG  = 3'h7;
  localparam int CFG_IDX_BASE = 0;
  localparam int CFG_IDX_MODE = 1;
  localparam int CFG_IDX_FWP  = 2;
  localparam int MODE_BIT_ENH2    = 0;
  localparam int MODE_BIT_DENSITY = 1;
  localparam int MODE_BIT_IDENT   = 2;
  localparam int OCR_BIT_SOFTRST  = 2;
  localparam int OCR_BIT_DMAEN    = 3;
  localparam int FWP_BIT_FORCE    = 0;
  localparam logic [7:0] OCR_RESET  = 8'h00;
  localparam logic [7:0] TAPE_RESET = 8'h00;
  localparam logic [7:0] RATE_RESET = 8'h02;
  localparam logic [7:0] CFG_RESET  = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h06;
  typedef enum {FHR_FULL_HOST, FHR_ALT_STATUS, FHR_COMPACT} fhr_mode_t;
  typedef struct packed {
    logic writeProtectN;
    logic indexPulseN;
    logic trackZeroN;
  } fhr_disk_in_t;
  typedef struct packed {
    logic stepOut;
    logic stepDirIn;
    logic headSide;
    logic floppyInterruptOut;
    logic dmaRequest;
    logic [7:0] mainStatus;
    logic [7:0] queueData;
    logic diskChange;
  } fhr_core_t;
endpackage : fhr_pkg

// ===== verilog/fhr_sync.sv
module fhr_sync
  import fhr_pkg::*;
#(
  parameter int WIDTH = 3
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_reg;
  // two flops; only the second stage is seen by the register file
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      stage1_reg <= '1;
      syncOut    <= '1;
    end else begin
      stage1_reg <= asyncIn;
      syncOut    <= stage1_reg;
    end
  end
endmodule : fhr_sync

// ===== test/fhr_host_model.sv
module fhr_host_model
  import fhr_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic [7:0]  hostDataOut,
  input  wire logic        hostDataOe_b,
  output logic      [15:0] hostAddr,
  output logic      [7:0]  hostDataIn,
  output logic             hostRead,
  output logic             hostWrite,
  output logic             dmaAck,
  output logic             configState,
  output logic      [1:0]  cfgIndex,
  output logic             cfgWrite,
  output logic      [7:0]  cfgData
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    hostAddr = 16'h0000;
    hostDataIn = 8'hA5;
    hostRead = 1'b0;
    hostWrite = 1'b0;
    dmaAck = 1'b0;
    configState = 1'b0;
    cfgIndex = 2'h0;
    cfgWrite = 1'b0;
    cfgData = 8'h5A;
  end
  task automatic io(input logic r, input logic w, input logic k,
                    input logic [15:0] a, input logic [7:0] v,
                    output logic [7:0] q, output logic z);
    @(posedge sys_clk) #1;
    hostAddr = a;
    hostDataIn = v;
    hostRead = r;
    hostWrite = w;
    dmaAck = k;
    @(posedge sys_clk) #1;
    // undriven bus reads as its pull-up level, not a stale byte
    q = hostDataOe_b ? 8'hFF : hostDataOut;
    z = hostDataOe_b;
    hostRead = 1'b0;
    hostWrite = 1'b0;
    dmaAck = 1'b0;
    // released bus flips so a stale byte cannot pass
    hostDataIn = ~v;
  endtask : io
  task automatic cfgw(input logic s, input logic [1:0] i,
                      input logic [7:0] v);
    @(posedge sys_clk) #1;
    configState = s;
    cfgIndex = i;
    cfgData = v;
    cfgWrite = 1'b1;
    @(posedge sys_clk) #1;
    cfgWrite = 1'b0;
    configState = 1'b0;
    cfgData = ~v;
  endtask : cfgw
endmodule : fhr_host_model

// ===== test/tb_fhr_front_end.sv
module tb_fhr_front_end
  import fhr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [7:0] mode;
    logic [2:0] disk;
    logic [3:0] core;
    logic [7:0] exp;
    logic [3:0] out;
  } fhr_row_t;
  localparam logic [7:0] BASE = 8'h7E;
  localparam fhr_row_t ROWS [7] = '{
    '{8'h02, 3'h5, 4'hA, 8'hD3, 4'h1}, '{8'h02, 3'h2, 4'h5, 8'h4C, 4'h1},
    '{8'h00, 3'h5, 4'hA, 8'h8C, 4'h4}, '{8'h00, 3'h2, 4'h5, 8'h53, 4'h4},
    '{8'h06, 3'h5, 4'hA, 8'h00, 4'hE}, '{8'h04, 3'h5, 4'hA, 8'h00, 4'hE},
    '{8'h03, 3'h5, 4'hA, 8'hD3, 4'h1}};
  logic         sys_clk = 1'b0;
  logic         rst_b = 1'b0;
  fhr_disk_in_t diskIn = 3'h5;
  fhr_core_t    coreIn = '0;
  logic [15:0]  hostAddr;
  logic [7:0]   hostDataIn, hostDataOut, cfgData, d, outputControl;
  logic [7:0]   tapeAssign, rateSelect, rateConfig, queueWriteData;
  logic [1:0]   cfgIndex;
  logic         hostDataOe_b, hostRead, hostWrite, dmaAck, configState;
  logic         cfgWrite, softResetActive, enhancedMode2, dmaEnable, oe;
  logic         dmaPinsDriven, terminalCountHigh, densitySelectHigh;
  logic         queueWrite, queueRead;
  int           n_mismatch = 0;
  int           check_count = 0;
  int           cycleCount = 0;
  int           queueReads = 0;
  always #2 sys_clk = ~sys_clk;
  // queue read strobe stands only while the request does
  always @(posedge sys_clk) begin
    if (queueRead) queueReads <= queueReads + 1;
  end
  fhr_front_end fhr_front_end_i (.sys_clk, .rst_b, .hostAddr, .hostDataIn,
    .hostDataOut, .hostDataOe_b, .hostRead, .hostWrite, .dmaAck,
    .configState, .cfgIndex, .cfgWrite, .cfgData, .diskIn, .coreIn,
    .softResetActive, .enhancedMode2, .dmaEnable, .dmaPinsDriven,
    .terminalCountHigh, .densitySelectHigh, .outputControl, .tapeAssign,
    .rateSelect, .rateConfig, .queueWriteData, .queueWrite, .queueRead);
  fhr_host_model fhr_host_model_i (.sys_clk, .hostDataOut, .hostDataOe_b,
    .hostAddr, .hostDataIn, .hostRead, .hostWrite, .dmaAck, .configState,
    .cfgIndex, .cfgWrite, .cfgData);
  task automatic end_of_test();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic rd(input logic [2:0] o, input logic k);
    fhr_host_model_i.io(1'b1, 1'b0, k, k ? 16'h0000 : {5'h00, BASE, o},
                        8'h00, d, oe);
  endtask : rd
  task automatic wr(input logic [2:0] o, input logic [7:0] v, input logic k);
    fhr_host_model_i.io(1'b0, 1'b1, k, {5'h00, BASE, o}, v, d, oe);
  endtask : wr
  task automatic cfgw(input logic s, input logic [1:0] i, input logic [7:0] v);
    fhr_host_model_i.cfgw(s, i, v);
  endtask : cfgw
  // hang guard, whole run is under a hundred cycles
  always @(posedge sys_clk) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 5000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    coreIn.mainStatus = 8'h81;
    coreIn.queueData = 8'h5A;
    chk("ocr", OCR_RESET, outputControl);
    chk("srst", 8'h01, {7'h00, softResetActive});
    chk("rsel", RATE_RESET, rateSelect);
    rd(OFS_OUT_CTRL, 1'b0);
    chk("offOe", 8'h01, {7'h00, oe});
    cfgw(1'b0, 2'h0, BASE);
    rd(OFS_OUT_CTRL, 1'b0);
    chk("lockOe", 8'h01, {7'h00, oe});
    cfgw(1'b1, 2'h0, BASE);
    foreach (ROWS[i]) begin
      diskIn = ROWS[i].disk;
      {coreIn.stepDirIn, coreIn.headSide} = ROWS[i].core[3:2];
      {coreIn.floppyInterruptOut, coreIn.dmaRequest} = ROWS[i].core[1:0];
      cfgw(1'b1, 2'h1, ROWS[i].mode);
      rd(OFS_STATUS_A, 1'b0);
      chk("oe", {7'h00, ROWS[i].out[3]}, {7'h00, oe});
      if (!ROWS[i].out[3]) chk("sra", ROWS[i].exp, d);
      chk("pins", {5'h00, ROWS[i].out[2:0]}, {5'h00, terminalCountHigh,
          densitySelectHigh, dmaPinsDriven});
      chk("enh", {7'h00, ROWS[i].mode[0]}, {7'h00, enhancedMode2});
    end
    cfgw(1'b1, 2'h2, 8'h01);
    rd(OFS_STATUS_A, 1'b0);
    chk("fwp", 8'hD1, d);
    cfgw(1'b1, 2'h2, 8'h00);
    wr(OFS_OUT_CTRL, 8'h04, 1'b0);
    chk("srst", 8'h00, {7'h00, softResetActive});
    cfgw(1'b1, 2'h1, 8'h00);
    coreIn.stepOut = 1'b1;
    @(posedge sys_clk) #1;
    coreIn.stepOut = 1'b0;
    rd(OFS_STATUS_A, 1'b0);
    chk("latch", 8'hAC, d);
    rd(OFS_INPUT_CFG, 1'b0);
    chk("inp", 8'h7F, d);
    rd(OFS_STATUS_A, 1'b0);
    chk("clr", 8'h8C, d);
    cfgw(1'b1, 2'h1, 8'h06);
    wr(OFS_OUT_CTRL, 8'h0C, 1'b0);
    chk("drv", 8'h01, {7'h00, dmaPinsDriven});
    chk("dmaEn", 8'h01, {7'h00, dmaEnable});
    rd(OFS_OUT_CTRL, 1'b0);
    chk("ocrRd", 8'h0C, d);
    wr(OFS_OUT_CTRL, 8'h08, 1'b0);
    chk("srstOn", 8'h01, {7'h00, softResetActive});
    wr(OFS_OUT_CTRL, 8'h0C, 1'b0);
    chk("srstOff", 8'h00, {7'h00, softResetActive});
    wr(OFS_TAPE, 8'h02, 1'b0);
    chk("tapeOut", 8'h02, tapeAssign);
    rd(OFS_TAPE, 1'b0);
    chk("tape", 8'h02, d);
    wr(OFS_DATA_QUEUE, 8'h96, 1'b0);
    chk("qData", 8'h96, queueWriteData);
    chk("qWrPio", 8'h01, {7'h00, queueWrite});
    wr(OFS_MAIN_RATE, 8'h01, 1'b0);
    chk("rsel", 8'h01, rateSelect);
    wr(OFS_INPUT_CFG, 8'h03, 1'b0);
    chk("rcfg", 8'h03, rateConfig);
    rd(OFS_MAIN_RATE, 1'b0);
    chk("main", 8'h81, d);
    rd(OFS_DATA_QUEUE, 1'b0);
    chk("queue", 8'h5A, d);
    chk("qRd", 8'h01, queueReads[7:0]);
    rd(3'h6, 1'b0);
    chk("resOe", 8'h01, {7'h00, oe});
    rd(3'h0, 1'b1);
    chk("dmaRd", 8'h5A, d);
    chk("qRdDma", 8'h02, queueReads[7:0]);
    wr(3'h1, 8'h3C, 1'b1);
    chk("dmaWr", 8'h3C, queueWriteData);
    chk("qWrDma", 8'h01, {7'h00, queueWrite});
    cfgw(1'b1, 2'h3, 8'h00);
    rd(OFS_OUT_CTRL, 1'b0);
    chk("disOe", 8'h01, {7'h00, oe});
    end_of_test();
  end
endmodule : tb_fhr_front_end
